// ==== wsc_pkg.sv ====
// package: constants, register map and carrier types of the reference window and align cal
package wsc_pkg;

  // ==========================================================
  // bus and field widths
  localparam int ADDR_W = 12;          // register port address width
  localparam int DATA_W = 8;           // register port data width
  localparam int NUM_POS = 24;         // candidate capture phases reported
  localparam int SEL_W = 4;            // selector reaches the first sixteen phases
  localparam int CODE_W = 8;           // coarse and fine delay code width (256 settings)
  localparam int EDGE_W = 4;           // edges-per-step count width
  localparam int SYNC_W = NUM_POS + 2; // pins passed through the synchroniser

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CLK_CTRL = 12'h029;   // phase select, step, single channel
  localparam logic [ADDR_W-1:0] OFS_WIN_RESTART = 12'h02b; // write restarts the detector
  localparam logic [ADDR_W-1:0] OFS_FLAGS_LOW = 12'h02c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_MID = 12'h02d;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_HIGH = 12'h02e;
  localparam logic [ADDR_W-1:0] OFS_DLY_INV = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_DLY_COARSE = 12'h031;
  localparam logic [ADDR_W-1:0] OFS_DLY_FINE = 12'h032;
  localparam logic [ADDR_W-1:0] OFS_CAL_EN = 12'h033;
  localparam logic [ADDR_W-1:0] OFS_CAL_CFG = 12'h034;
  localparam logic [ADDR_W-1:0] OFS_CAL_STATUS = 12'h035;
  localparam logic [ADDR_W-1:0] OFS_RES_INV = 12'h036;
  localparam logic [ADDR_W-1:0] OFS_RES_COARSE = 12'h037;
  localparam logic [ADDR_W-1:0] OFS_RES_FINE = 12'h038;

  // ==========================================================
  // field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_FINE_BIT = 4;
  localparam int CTRL_SCM_BIT = 5;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int POS_LOW_BIT = 0;
  localparam int POS_HIGH_BIT = NUM_POS - 1;

  // ==========================================================
  // reset values and limits
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
  localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] CODE_MAX = 8'hFF;
  localparam logic [EDGE_W-1:0] CFG_RESET = 4'h3;     // edges watched per search step
  localparam logic [EDGE_W-1:0] EDGE_ONE = 4'h1;
  localparam logic [1:0] VALID_EDGES = 2'h3;          // reference edges before flags are valid
  localparam logic [1:0] EDGE_CNT_ONE = 2'h1;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wsc_bus_t;

  typedef struct packed {
    logic inv;
    logic [CODE_W-1:0] coarse;
    logic [CODE_W-1:0] fine;
  } wsc_delay_t;

  typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_PICK, CAL_DONE} wsc_cal_state_t;

endpackage

// ==== wsc_sync.sv ====
// module: two-flop synchroniser for a group of pin levels
module wsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // ==========================================================
  // state: first stage is read only by the second stage
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } wsc_sync_st_t;

  wsc_sync_st_t st_r;
  wsc_sync_st_t st_nxt;

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = din;
    st_nxt.stable = st_r.meta;
  end

  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.stable;

endmodule

// ==== wsc_window_cell.sv ====
// module: one sticky setup/hold violation flag of the capture window map
module wsc_window_cell (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic clear,
  // neighbouring phase samples of the reference
  input wire logic lo,
  input wire logic mid,
  input wire logic hi,
  // result
  output logic flag
);

  // ==========================================================
  // state
  typedef struct packed {
    logic flag;
  } wsc_cell_st_t;

  wsc_cell_st_t st_r;
  wsc_cell_st_t st_nxt;

  // a transition landing next to this phase means the phase is marginal
  always_comb begin
    st_nxt = st_r;
    if ((mid != lo) || (mid != hi)) begin
      st_nxt.flag = 1'b1;       // set wins over a clear in the same cycle
    end else if (clear) begin
      st_nxt.flag = 1'b0;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

endmodule

// ==== wsc_sysref_align.sv ====
// module: timing reference capture, window detector and automatic aperture alignment
// What this block and its host must do
// RQ1: capture reference on a deterministic clock edge
// RQ2: single-channel mode samples on both edges
// RQ3: window flags valid after three reference edges
// RQ4: flag one marks a marginal capture phase
// RQ5: lowest and highest flags always read one
// RQ6: 24 flags, selector reaches only 16
// RQ7: selector index picks the delayed capture clock
// RQ8: step option zero coarse, one fine
// RQ9: host picks fine step above 3GHz
// RQ10: host applies clock, programs device first
// RQ11: reference stays periodic during alignment calibration
// RQ12: host writes config before calibration enable
// RQ13: enable starts search for falling-edge alignment
// RQ14: search coarse codes on both clock polarities
// RQ15: done flag raised when search ends
// RQ16: found delay readable in result field
// RQ17: found delay stays applied while enabled
// RQ18: host may write stored delay directly
// RQ19: host pauses converter calibration during search
// RQ20: host keeps phase selector zero during calibration
// RQ21: inversion, coarse, fine combine independently, 256 coarse and 256 fine codes
// RQ22: clearing enable drops done, returns host delay
//
// Design decision made here: the plain strobed port.
module wsc_sysref_align
  import wsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire wsc_pkg::wsc_bus_t bus,
  output logic [wsc_pkg::DATA_W-1:0] rdata,
  // reference sampled by each delayed clock phase, from the delay line
  input wire logic [wsc_pkg::NUM_POS-1:0] phase_samples,
  // reference sampled on the clock falling edge, used in single-channel mode
  input wire logic sysref_fall_sample,
  // phase detector: reference rises before the internal clock falling edge
  input wire logic align_early,
  // capture and delay-line controls
  output logic sysref_capture,
  output logic dual_edge_sampling,
  output logic [wsc_pkg::SEL_W-1:0] capture_phase_select,
  output logic window_step_fine,
  output wsc_pkg::wsc_delay_t aperture_delay
);

  // ==========================================================
  // state of the block
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [SEL_W-1:0] phase_sel;
    logic step_fine;
    logic single_ch;
    wsc_delay_t host_dly;
    logic cal_en;
    logic [EDGE_W-1:0] cfg_edges;
    wsc_cal_state_t cal_state;
    wsc_delay_t search;
    logic [EDGE_W-1:0] step_edges;
    logic found0;
    logic [CODE_W-1:0] code0;
    logic found1;
    logic [CODE_W-1:0] code1;
    wsc_delay_t result;
    logic done;
    logic [1:0] ref_edges;
    logic ref_prev;
    logic cap_prev;
    logic cap_pulse;
  } wsc_st_t;

  wsc_st_t st_r;
  wsc_st_t st_nxt;

  logic [SYNC_W-1:0] pins_s;          // synchronised pin levels
  logic [NUM_POS-1:0] ph_s;           // synchronised phase samples
  logic fall_s;                        // synchronised falling-edge sample
  logic early_s;                       // synchronised detector output
  logic [NUM_POS-1:0] cell_flag;       // raw sticky flags
  logic [NUM_POS-1:0] win_flags;       // flags as software sees them
  logic win_clear;                     // detector restart
  logic ref_rise;                      // reference rising edge at phase zero
  logic cap_now;                       // reference level at the chosen phase

  // ==========================================================
  // pin synchroniser: every pin is two flops away from logic
  wsc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .din({align_early, sysref_fall_sample, phase_samples}),
    .dout(pins_s)
  );

  assign ph_s = pins_s[NUM_POS-1:0];
  assign fall_s = pins_s[NUM_POS];
  assign early_s = pins_s[NUM_POS+1];

  // ==========================================================
  // window detector: one cell per interior phase
  assign win_clear = bus.wr && (bus.addr == OFS_WIN_RESTART);

  genvar gi;
  generate
    for (gi = 1; gi < NUM_POS - 1; gi++) begin : g_cell
      wsc_window_cell u_cell (
        .clk(clk),
        .reset(reset),
        .clear(win_clear),
        .lo(ph_s[gi-1]),
        .mid(ph_s[gi]),
        .hi(ph_s[gi+1]),
        .flag(cell_flag[gi])
      );
    end
  endgenerate

  // end phases have no neighbour on one side, so they are never trusted
  assign cell_flag[POS_LOW_BIT] = 1'b1;   // RQ5
  assign cell_flag[POS_HIGH_BIT] = 1'b1;  // RQ5
  assign win_flags = cell_flag;           // RQ4

  // ==========================================================
  // capture at the selected delayed phase; dual edge adds the falling sample
  assign ref_rise = ph_s[0] && !st_r.ref_prev;
  assign cap_now = ph_s[st_r.phase_sel] || (st_r.single_ch && fall_s); // RQ7 RQ2

  // ==========================================================
  // next state: register port, detector edge count, capture, calibration
  always_comb begin
    st_nxt = st_r;
    st_nxt.ref_prev = ph_s[0];
    st_nxt.cap_prev = cap_now;
    // one pulse per reference rising edge, always on the same clock edge
    st_nxt.cap_pulse = cap_now && !st_r.cap_prev;  // RQ1

    // edge count for flag validity, saturating
    if (win_clear) begin
      st_nxt.ref_edges = '0;
    end else if (ref_rise && (st_r.ref_edges != VALID_EDGES)) begin
      st_nxt.ref_edges = st_r.ref_edges + EDGE_CNT_ONE;  // RQ3
    end

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        OFS_CLK_CTRL: begin
          // selector field is four bits wide, so only phases 0..15 can be selected
          st_nxt.phase_sel = bus.wdata[CTRL_SEL_LSB +: SEL_W];  // RQ6
          st_nxt.step_fine = bus.wdata[CTRL_FINE_BIT];          // RQ8
          st_nxt.single_ch = bus.wdata[CTRL_SCM_BIT];           // RQ2
        end
        OFS_DLY_INV: st_nxt.host_dly.inv = bus.wdata[0];         // RQ21
        OFS_DLY_COARSE: st_nxt.host_dly.coarse = bus.wdata;      // RQ21
        OFS_DLY_FINE: st_nxt.host_dly.fine = bus.wdata;          // RQ21
        OFS_CAL_EN: st_nxt.cal_en = bus.wdata[0];
        OFS_CAL_CFG: st_nxt.cfg_edges = bus.wdata[EDGE_W-1:0];
        default: begin
        end
      endcase
    end

    // register reads, data stand one cycle later
    st_nxt.rdata = ZERO_BYTE;
    if (bus.rd) begin
      case (bus.addr)
        OFS_CLK_CTRL: begin
          st_nxt.rdata[CTRL_SEL_LSB +: SEL_W] = st_r.phase_sel;
          st_nxt.rdata[CTRL_FINE_BIT] = st_r.step_fine;
          st_nxt.rdata[CTRL_SCM_BIT] = st_r.single_ch;
        end
        OFS_FLAGS_LOW: st_nxt.rdata = win_flags[7:0];
        OFS_FLAGS_MID: st_nxt.rdata = win_flags[15:8];
        OFS_FLAGS_HIGH: st_nxt.rdata = win_flags[23:16];
        OFS_DLY_INV: st_nxt.rdata[0] = st_r.host_dly.inv;
        OFS_DLY_COARSE: st_nxt.rdata = st_r.host_dly.coarse;
        OFS_DLY_FINE: st_nxt.rdata = st_r.host_dly.fine;
        OFS_CAL_EN: st_nxt.rdata[0] = st_r.cal_en;
        OFS_CAL_CFG: st_nxt.rdata[EDGE_W-1:0] = st_r.cfg_edges;
        OFS_CAL_STATUS: begin
          st_nxt.rdata[STAT_DONE_BIT] = st_r.done;                          // RQ15
          st_nxt.rdata[STAT_VALID_BIT] = (st_r.ref_edges == VALID_EDGES);   // RQ3
          st_nxt.rdata[STAT_BUSY_BIT] = (st_r.cal_state == CAL_SETTLE)
                                        || (st_r.cal_state == CAL_PICK);
        end
        OFS_RES_INV: st_nxt.rdata[0] = st_r.result.inv;       // RQ16
        OFS_RES_COARSE: st_nxt.rdata = st_r.result.coarse;    // RQ16
        OFS_RES_FINE: st_nxt.rdata = st_r.result.fine;        // RQ16
        default: st_nxt.rdata = ZERO_BYTE;
      endcase
    end

    // alignment search
    case (st_r.cal_state)
      CAL_IDLE: begin
        st_nxt.done = 1'b0;
        if (st_r.cal_en) begin
          // start on the non-inverted polarity at the smallest coarse code
          st_nxt.search.inv = 1'b0;                 // RQ13
          st_nxt.search.coarse = CODE_ZERO;
          st_nxt.search.fine = st_r.host_dly.fine;
          st_nxt.step_edges = '0;
          st_nxt.found0 = 1'b0;
          st_nxt.found1 = 1'b0;
          st_nxt.cal_state = CAL_SETTLE;
        end
      end
      CAL_SETTLE: begin
        if (!st_r.cal_en) begin
          st_nxt.cal_state = CAL_IDLE;              // RQ22
        end else if (ref_rise) begin
          st_nxt.step_edges = st_r.step_edges + EDGE_ONE;
          // judge the setting only after the delay has settled for a few edges
          if ((st_r.step_edges + EDGE_ONE) >= st_r.cfg_edges) begin
            st_nxt.step_edges = '0;
            if (!early_s || (st_r.search.coarse == CODE_MAX)) begin
              // aligned (or code range exhausted) on this polarity
              if (!st_r.search.inv) begin
                st_nxt.found0 = !early_s;
                st_nxt.code0 = st_r.search.coarse;
                st_nxt.search.inv = 1'b1;           // RQ14
                st_nxt.search.coarse = CODE_ZERO;
              end else begin
                st_nxt.found1 = !early_s;
                st_nxt.code1 = st_r.search.coarse;
                st_nxt.cal_state = CAL_PICK;
              end
            end else begin
              st_nxt.search.coarse = st_r.search.coarse + 8'h01;
            end
          end
        end
      end
      CAL_PICK: begin
        // keep the polarity needing the smaller coarse code, less clock path loss
        st_nxt.result.fine = st_r.search.fine;
        if (st_r.found1 && (!st_r.found0 || (st_r.code1 < st_r.code0))) begin
          st_nxt.result.inv = 1'b1;                 // RQ14
          st_nxt.result.coarse = st_r.code1;
        end else begin
          st_nxt.result.inv = 1'b0;                 // RQ14
          st_nxt.result.coarse = st_r.code0;
        end
        st_nxt.done = 1'b1;                         // RQ15
        st_nxt.cal_state = CAL_DONE;
      end
      CAL_DONE: begin
        if (!st_r.cal_en) begin
          st_nxt.done = 1'b0;                       // RQ22
          st_nxt.cal_state = CAL_IDLE;
        end
      end
      default: st_nxt.cal_state = CAL_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.cfg_edges <= CFG_RESET;
      st_r.phase_sel <= SEL_RESET;
      st_r.cal_state <= CAL_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rdata = st_r.rdata;
  assign sysref_capture = st_r.cap_pulse;
  assign dual_edge_sampling = st_r.single_ch;     // RQ2
  assign capture_phase_select = st_r.phase_sel;   // RQ7
  assign window_step_fine = st_r.step_fine;       // RQ8

  // search setting while sweeping, found setting once done, host fields otherwise
  always_comb begin
    case (st_r.cal_state)
      CAL_SETTLE: aperture_delay = st_r.search;   // RQ13
      CAL_PICK: aperture_delay = st_r.search;
      CAL_DONE: aperture_delay = st_r.result;     // RQ17
      default: aperture_delay = st_r.host_dly;    // RQ22 RQ18
    endcase
  end

endmodule

// ==== wsc_refgen.sv ====
// partner model: reference source and falling-edge detector of the system clock generator
module wsc_refgen
  import wsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // scenario controls
  input wire logic run,
  input wire logic [4:0] edge_pos,
  input wire logic [wsc_pkg::CODE_W-1:0] tgt0,
  input wire logic [wsc_pkg::CODE_W-1:0] tgt1,
  // delay applied by the block
  input wire wsc_pkg::wsc_delay_t aperture_delay,
  // reference as the block sees it
  output logic [wsc_pkg::NUM_POS-1:0] phase_samples,
  output logic sysref_fall_sample,
  output logic align_early
);
  // ==========================================================
  // reference waveform
  logic [2:0] cnt_r; // eight-cycle period
  logic ref_r; // level seen by the later phases
  logic ref_d_r; // same edge one cycle later, seen by earlier phases

  // periodic while running; a stopped source rests low
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      cnt_r <= 3'h0;
      ref_r <= 1'b0;
      ref_d_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      ref_r <= (cnt_r < 3'h4);
      ref_d_r <= ref_r;
    end
  end

  // ==========================================================
  // phase map and detector
  // phases at or above edge_pos see the edge first, so the only mismatch sits at the boundary
  always_comb begin
    for (int i = 0; i < NUM_POS; i++) begin
      phase_samples[i] = (5'(i) >= edge_pos) ? ref_r : ref_d_r;
    end
  end
  assign sysref_fall_sample = ref_d_r;
  // early while the coarse code is below the target of the polarity in use
  assign align_early = aperture_delay.coarse < (aperture_delay.inv ? tgt1 : tgt0);
endmodule

// ==== wsc_sysref_align_monitor.sv ====
// checker: port-level properties of the reference window and alignment block
module wsc_sysref_align_monitor
  import wsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire wsc_pkg::wsc_bus_t bus,
  input wire logic [wsc_pkg::DATA_W-1:0] rdata,
  // reference pins
  input wire logic [wsc_pkg::NUM_POS-1:0] phase_samples,
  // controls
  input wire logic sysref_capture,
  input wire logic dual_edge_sampling,
  input wire logic [wsc_pkg::SEL_W-1:0] capture_phase_select,
  input wire logic window_step_fine,
  input wire wsc_pkg::wsc_delay_t aperture_delay
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // helper state
  wsc_delay_t host_dly_r; // host-written delay fields
  logic cal_on_r; // enable bit as last written
  logic [1:0] idle_cnt_r; // cycles since enable low, saturates at 3
  logic [1:0] edges_r; // pin-level reference edges since restart, saturates
  logic ref0_d_r; // phase zero one cycle back

  // mirror writes; counters give the block its documented settling slack
  always_ff @(posedge clk) begin
    if (reset) begin
      host_dly_r <= '0;
      cal_on_r <= 1'b0;
      idle_cnt_r <= 2'h3;
      edges_r <= 2'h0;
      ref0_d_r <= 1'b0;
    end else begin
      if (bus.wr && bus.addr == OFS_DLY_INV) host_dly_r.inv <= bus.wdata[0];
      if (bus.wr && bus.addr == OFS_DLY_COARSE) host_dly_r.coarse <= bus.wdata;
      if (bus.wr && bus.addr == OFS_DLY_FINE) host_dly_r.fine <= bus.wdata;
      if (bus.wr && bus.addr == OFS_CAL_EN) cal_on_r <= bus.wdata[0];
      if (cal_on_r) idle_cnt_r <= 2'h0;
      else if (idle_cnt_r != 2'h3) idle_cnt_r <= idle_cnt_r + 2'h1;
      if (bus.wr && bus.addr == OFS_WIN_RESTART) edges_r <= 2'h0;
      else if (phase_samples[0] && !ref0_d_r && edges_r != 2'h3) edges_r <= edges_r + 2'h1;
      ref0_d_r <= phase_samples[0];
    end
  end

  // ==========================================================
  // assertions
  a_ctrl_select: assert property (bus.wr && bus.addr == OFS_CLK_CTRL
    |=> capture_phase_select == $past(bus.wdata[3:0])) else $error("select not applied");
  a_step_fine: assert property (bus.wr && bus.addr == OFS_CLK_CTRL
    |=> window_step_fine == $past(bus.wdata[4])) else $error("step option not applied");
  a_dual_edge: assert property (bus.wr && bus.addr == OFS_CLK_CTRL
    |=> dual_edge_sampling == $past(bus.wdata[5])) else $error("dual edge not applied");
  a_capture_rise: assert property (!dual_edge_sampling && $stable(capture_phase_select)
    && $rose(phase_samples[capture_phase_select]) |-> ##[2:4] sysref_capture)
    else $error("reference rise not captured");
  a_flag_low_set: assert property (bus.rd && bus.addr == OFS_FLAGS_LOW
    |=> rdata[0]) else $error("lowest flag reads zero");
  a_flag_high_set: assert property (bus.rd && bus.addr == OFS_FLAGS_HIGH
    |=> rdata[7]) else $error("highest flag reads zero");
  a_valid_early: assert property (bus.rd && bus.addr == OFS_CAL_STATUS && edges_r < 2'h2
    |=> !rdata[STAT_VALID_BIT]) else $error("flags valid too early");
  a_host_delay: assert property (idle_cnt_r == 2'h3
    |-> aperture_delay == host_dly_r) else $error("host delay not applied");
  a_cal_start: assert property (bus.wr && bus.addr == OFS_CAL_EN && bus.wdata[0]
    && idle_cnt_r == 2'h3 |-> ##2 (aperture_delay.coarse == CODE_ZERO && !aperture_delay.inv))
    else $error("search did not start at code zero");
  a_done_clear: assert property (bus.rd && bus.addr == OFS_CAL_STATUS && idle_cnt_r == 2'h3
    |=> !rdata[STAT_DONE_BIT]) else $error("done flag without enable");

  // ==========================================================
  // coverage of the main scenarios
  c_capture: cover property (sysref_capture);
  c_cal_start: cover property (bus.wr && bus.addr == OFS_CAL_EN && bus.wdata[0]);
  c_flag_read: cover property (bus.rd && bus.addr == OFS_FLAGS_HIGH);
endmodule

bind wsc_sysref_align wsc_sysref_align_monitor u_mon (
  .clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .phase_samples(phase_samples),
  .sysref_capture(sysref_capture), .dual_edge_sampling(dual_edge_sampling),
  .capture_phase_select(capture_phase_select), .window_step_fine(window_step_fine),
  .aperture_delay(aperture_delay));

// ==== wsc_sysref_align_tb.sv ====
// testbench: register, window, capture and calibration scenarios of the alignment block
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("unexpected %s: expected %h, seen %h", nm, e, g); \
    end \
  end

module wsc_sysref_align_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wsc_pkg::*;

  // ==========================================================
  // signals
  logic clk, reset, run, dual, step, cap, fall, early;
  wsc_bus_t bus; // register port request
  logic [DATA_W-1:0] rdata;
  logic [NUM_POS-1:0] phases;
  logic [SEL_W-1:0] sel;
  wsc_delay_t dly;
  logic [4:0] edge_pos; // window boundary offered by the source
  logic [CODE_W-1:0] tgt0, tgt1; // alignment codes per polarity
  logic [27:0] exp_q[$]; // {addr, mask, expected} per read
  logic [27:0] note;
  logic rd_pend;
  int seed = 3974;
  int error_cnt = 0;
  int num_checks = 0;

  // ==========================================================
  // design and partner
  wsc_sysref_align u_wsc_sysref_align (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .phase_samples(phases), .sysref_fall_sample(fall), .align_early(early),
    .sysref_capture(cap), .dual_edge_sampling(dual), .capture_phase_select(sel),
    .window_step_fine(step), .aperture_delay(dly));
  wsc_refgen u_wsc_refgen (.clk(clk), .reset(reset), .run(run), .edge_pos(edge_pos),
    .tgt0(tgt0), .tgt1(tgt1), .aperture_delay(dly), .phase_samples(phases),
    .sysref_fall_sample(fall), .align_early(early));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // register tasks: one-cycle strobes with a spare cycle so no strobe is set twice per step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdm(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({a, m, e});
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rdm(a, e, 8'hff);
  endtask

  // read data stand only in the cycle after the strobe; compare there against the oldest note
  always @(posedge clk) begin
    if (rd_pend) begin
      note = exp_q.pop_front();
      `CHK($sformatf("rdata_%h", note[27:16]), note[7:0] & note[15:8], rdata & note[15:8])
    end
    rd_pend <= bus.rd;
  end

  // verdict in one place
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog far beyond the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] v;
    logic [15:0] d;
    logic [23:0] f;
    logic ei;
    logic [7:0] ec;
    int n;
    logic [4:0] kp[4] = '{5'd5, 5'd12, 5'd16, 5'd23};
    logic [7:0] t0[3] = '{8'h05, 8'h02, 8'h03};
    logic [7:0] t1[3] = '{8'h03, 8'h04, 8'h03};
    bus = '0;
    reset = 1'b1;
    run = 1'b0;
    edge_pos = 5'd5;
    tgt0 = 8'h05;
    tgt1 = 8'h03;
    rd_pend = 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // reset values and an unmapped place
    rd(OFS_CLK_CTRL, 8'h00);
    rd(OFS_CAL_CFG, {4'h0, CFG_RESET});
    rd(OFS_CAL_STATUS, 8'h00);
    rd(12'h0ff, 8'h00);
    // control fields with the source stopped
    repeat (4) begin
      v = 8'($random(seed)) & 8'h3f;
      wr(OFS_CLK_CTRL, v);
      rd(OFS_CLK_CTRL, v);
      `CHK("select", v[3:0], sel)
      `CHK("step", v[4], step)
      `CHK("dual", v[5], dual)
    end
    // one capture pulse per reference period
    wr(OFS_CLK_CTRL, 8'h00);
    run <= 1'b1;
    repeat (20) @(posedge clk);
    n = 0;
    repeat (80) begin
      @(posedge clk);
      if (cap === 1'b1) n++;
    end
    `CHK("captures", 10, n)
    // window map at several boundaries, some beyond the selector reach
    foreach (kp[i]) begin
      edge_pos <= kp[i];
      repeat (10) @(posedge clk);
      wr(OFS_WIN_RESTART, 8'h00);
      rd(OFS_CAL_STATUS, 8'h00);
      repeat (40) @(posedge clk);
      rd(OFS_CAL_STATUS, 8'h02);
      f = 24'h80_0001 | (24'h1 << kp[i]) | (24'h1 << (kp[i] - 5'd1));
      rd(OFS_FLAGS_LOW, f[7:0]);
      rd(OFS_FLAGS_MID, f[15:8]);
      rd(OFS_FLAGS_HIGH, f[23:16]);
    end
    // host-programmed delay
    d = 16'($random(seed));
    wr(OFS_DLY_INV, 8'h01);
    wr(OFS_DLY_COARSE, d[15:8]);
    wr(OFS_DLY_FINE, d[7:0]);
    rd(OFS_DLY_COARSE, d[15:8]);
    `CHK("host_delay", {1'b1, d}, dly)
    // calibration: inverted wins, plain wins, tie goes to plain
    for (int i = 0; i < 3; i++) begin
      tgt0 <= t0[i];
      tgt1 <= t1[i];
      ei = t1[i] < t0[i];
      ec = ei ? t1[i] : t0[i];
      wr(OFS_CLK_CTRL, 8'h00);
      wr(OFS_CAL_CFG, 8'h02);
      wr(OFS_CAL_EN, 8'h01);
      n = 0;
      do begin
        rdm(OFS_CAL_STATUS, 8'h00, 8'h00);
        n++;
      end while (rdata[STAT_DONE_BIT] !== 1'b1 && n < 200);
      // a poll limit that runs out counts as a mismatch here
      `CHK("cal_done_poll", 1'b1, rdata[STAT_DONE_BIT])
      rd(OFS_CAL_STATUS, 8'h03);
      rd(OFS_RES_INV, {7'h00, ei});
      rd(OFS_RES_COARSE, ec);
      rd(OFS_RES_FINE, d[7:0]);
      repeat (20) @(posedge clk);
      `CHK("cal_delay", {ei, ec, d[7:0]}, dly)
      wr(OFS_CAL_EN, 8'h00);
      @(posedge clk);
      rd(OFS_CAL_STATUS, 8'h02);
      `CHK("host_back", {1'b1, d}, dly)
    end
    give_verdict();
  end
endmodule
